// ==== design/adc_seq_consts.svh ====
// register offsets, field positions, reset values and timing counts of the converter sequencer
// assumes inclusion from the package, the top module and the testbench
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ====================================================================
// register byte offsets
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_CTRL2 12'h008
`define OFS_BGAP 12'h00C
`define OFS_PINSEL 12'h010

// ====================================================================
// control register 0 fields and the bandgap register enable bit
`define C0_CHAN_LSB 0
`define C0_START_BIT 4
`define C0_BUSY_BIT 6
`define C0_PWR_BIT 5
`define C0_FLAG_BIT 7
`define BGAP_EN_BIT 0
// control register 1 fields
`define C1_CKDIV_LSB 0
`define C1_SRC_LSB 4
// control register 2 fields
`define C2_GAIN_LSB 0
`define C2_REF_LSB 2
`define C2_AMPIN_BIT 4
`define C2_AMPEN_BIT 7

// ====================================================================
// reset values
`define RST_CTRL0 32'h0000_0000
`define RST_CTRL1 32'h0000_0000
`define RST_CTRL2 32'h0000_0000
`define RST_PINSEL 12'h000

// ====================================================================
// conversion timing in conversion clock periods, and the external channel count
`define SAMPLE_PERIODS 5'h04
`define CONVERT_PERIODS 5'h0C
`define TOTAL_PERIODS 5'h10
`define NUM_CHANNELS 12

`endif

// ==== design/adc_seq_pkg.sv ====
// types shared by the converter sequencer
// assumes the constants header sits beside it
`include "adc_seq_consts.svh"

package adc_seq_pkg;

    typedef enum logic [1:0] {
        REF_SUPPLY,
        REF_EXT_PIN,
        REF_AMP_OUT
    } ref_route_t;

    typedef enum logic [3:0] {
        IN_EXT_CHANNEL,
        IN_SUPPLY,
        IN_SUPPLY_HALF,
        IN_SUPPLY_QUARTER,
        IN_AMP,
        IN_AMP_HALF,
        IN_AMP_QUARTER,
        IN_GROUND
    } in_route_t;

    typedef enum logic [1:0] {
        GAIN_X1000,
        GAIN_X1667,
        GAIN_X2500,
        GAIN_X3333
    } gain_t;

    typedef struct packed {
        ref_route_t ref_route;
        logic ext_ref_connect;
        gain_t gain;
        logic amp_power;
        logic amp_from_bandgap;
        logic amp_pin_connect;
    } ref_ctrl_t;

    typedef struct packed {
        in_route_t in_route;
        logic [11:0] channel_onehot;
    } in_ctrl_t;

endpackage

// ==== design/adc_seq.sv ====
// converter control: reference and input routing, pin override, clock divider, sequencer
// assumes an AXI4-Lite master on CLK and an analog core driven by the routing outputs
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_consts.svh"

// ====================================================================
module adc_seq
    import adc_seq_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic CONV_DONE_IN,
    output ref_ctrl_t REF_CTRL,
    output in_ctrl_t IN_CTRL,
    output logic CONVERTER_POWER,
    output logic CONV_CLOCK_EN,
    output logic SAMPLE_PHASE,
    output logic CONVERT_PHASE,
    output logic CONV_DONE_IRQ,
    output logic BANDGAP_ENABLE,
    output logic [11:0] PIN_ANALOG_MODE,
    output logic [11:0] PIN_DIGITAL_DISABLE,
    output logic [11:0] PIN_PULLUP_DISCONNECT,
    output logic [11:0] PIN_DIR_INPUT_FORCE
);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_CONVERT
    } seq_state_t;

    // ====================================================================
    // register state
    logic [3:0] chan_q, chan_d;
    logic start_q, start_d;
    logic pwr_q, pwr_d;
    logic [2:0] ckdiv_q, ckdiv_d;
    logic [3:0] src_q, src_d;
    logic [1:0] gain_q, gain_d;
    logic [1:0] refsel_q, refsel_d;
    logic ampin_q, ampin_d;
    logic ampen_q, ampen_d;
    logic bgap_q, bgap_d;
    logic [11:0] pinsel_q, pinsel_d;
    logic irq_flag_q, irq_flag_d;
    logic aw_hold_q, aw_hold_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic w_hold_q, w_hold_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic start_armed_q, start_armed_d;
    logic start_fire;
    logic wr_go, irq_clear;

    // ====================================================================
    // AXI4-Lite write path: address and data taken in either order
    assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

    always_comb begin
        aw_hold_d = aw_hold_q;
        aw_addr_d = aw_addr_q;
        w_hold_d = w_hold_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        chan_d = chan_q;
        start_d = start_q;
        pwr_d = pwr_q;
        ckdiv_d = ckdiv_q;
        src_d = src_q;
        gain_d = gain_q;
        refsel_d = refsel_q;
        ampin_d = ampin_q;
        ampen_d = ampen_q;
        bgap_d = bgap_q;
        pinsel_d = pinsel_q;
        irq_clear = 1'b0;
        if (AWVALID && !aw_hold_q) begin
            aw_hold_d = 1'b1;
            aw_addr_d = AWADDR;
        end
        if (WVALID && !w_hold_q) begin
            w_hold_d = 1'b1;
            w_data_d = WDATA;
            w_strb_d = WSTRB;
        end
        if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            if (aw_addr_q == `OFS_CTRL0) begin
                if (w_strb_q[0]) begin
                    chan_d = w_data_q[`C0_CHAN_LSB +: 4];
                    start_d = w_data_q[`C0_START_BIT];
                    pwr_d = w_data_q[`C0_PWR_BIT];
                    irq_clear = !w_data_q[`C0_FLAG_BIT];
                end
            end else if (aw_addr_q == `OFS_CTRL1) begin
                if (w_strb_q[0]) begin
                    ckdiv_d = w_data_q[`C1_CKDIV_LSB +: 3];
                    src_d = w_data_q[`C1_SRC_LSB +: 4];
                end
            end else if (aw_addr_q == `OFS_CTRL2) begin
                if (w_strb_q[0]) begin
                    gain_d = w_data_q[`C2_GAIN_LSB +: 2];
                    refsel_d = w_data_q[`C2_REF_LSB +: 2];
                    ampin_d = w_data_q[`C2_AMPIN_BIT];
                    ampen_d = w_data_q[`C2_AMPEN_BIT];
                end
            end else if (aw_addr_q == `OFS_BGAP) begin
                if (w_strb_q[0]) begin
                    bgap_d = w_data_q[`BGAP_EN_BIT];
                end
            end else if (aw_addr_q == `OFS_PINSEL) begin
                if (w_strb_q[0]) begin
                    pinsel_d[7:0] = w_data_q[7:0];
                end
                if (w_strb_q[1]) begin
                    pinsel_d[11:8] = w_data_q[11:8];
                end
            end else begin
                bresp_d = 2'h3;
            end
        end
    end

    // ====================================================================
    // AXI4-Lite read path
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (rvalid_q && RREADY) begin
            rvalid_d = 1'b0;
        end
        if (ARVALID && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            rdata_d = 32'h0000_0000;
            if (ARADDR == `OFS_CTRL0) begin
                rdata_d[`C0_CHAN_LSB +: 4] = chan_q;
                rdata_d[`C0_START_BIT] = start_q;
                rdata_d[`C0_PWR_BIT] = pwr_q;
                rdata_d[`C0_BUSY_BIT] = SAMPLE_PHASE | CONVERT_PHASE;
                rdata_d[`C0_FLAG_BIT] = irq_flag_q;
            end else if (ARADDR == `OFS_CTRL1) begin
                rdata_d[`C1_CKDIV_LSB +: 3] = ckdiv_q;
                rdata_d[`C1_SRC_LSB +: 4] = src_q;
            end else if (ARADDR == `OFS_CTRL2) begin
                rdata_d[`C2_GAIN_LSB +: 2] = gain_q;
                rdata_d[`C2_REF_LSB +: 2] = refsel_q;
                rdata_d[`C2_AMPIN_BIT] = ampin_q;
                rdata_d[`C2_AMPEN_BIT] = ampen_q;
            end else if (ARADDR == `OFS_BGAP) begin
                rdata_d[`BGAP_EN_BIT] = bgap_q;
            end else if (ARADDR == `OFS_PINSEL) begin
                rdata_d[11:0] = pinsel_q;
            end else begin
                rresp_d = 2'h3;
            end
        end
    end

    // ====================================================================
    // start pulse detection: a high seen arms, the next low then fires
    always_comb begin
        start_armed_d = start_armed_q;
        start_fire = 1'b0;
        if (start_q) begin
            start_armed_d = 1'b1;
        end else if (start_armed_q) begin
            start_armed_d = 1'b0;
            start_fire = 1'b1;
        end
    end

    // ====================================================================
    // free-running divider producing one enable per period
    logic [6:0] div_q, div_d;
    logic [6:0] div_mask;
    logic tick;

    always_comb begin
        div_mask = 7'(8'h01 << ckdiv_q) - 7'h01;
        tick = ((div_q & div_mask) == div_mask);
        div_d = div_q + 7'h01;
    end

    // ====================================================================
    // conversion sequencer
    seq_state_t st_q, st_d;
    logic [4:0] cnt_q, cnt_d;
    logic done;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        done = 1'b0;
        case (st_q)
            SEQ_IDLE: begin
                cnt_d = 5'h00;
                if (start_fire && pwr_q) begin
                    st_d = SEQ_SAMPLE;
                end
            end
            SEQ_SAMPLE: begin
                if (tick) begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == `SAMPLE_PERIODS - 5'h01) begin
                        st_d = SEQ_CONVERT;
                    end
                end
            end
            SEQ_CONVERT: begin
                if (tick) begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == `TOTAL_PERIODS - 5'h01) begin
                        st_d = SEQ_IDLE;
                        done = 1'b1;
                    end
                end
            end
            default: begin
                st_d = SEQ_IDLE;
            end
        endcase
        if (!pwr_q) begin
            st_d = SEQ_IDLE;
            cnt_d = 5'h00;
        end
    end

    // request flag: set wins over software clear
    always_comb begin
        irq_flag_d = irq_flag_q;
        if (irq_clear) begin
            irq_flag_d = 1'b0;
        end
        if (done || CONV_DONE_IN) begin
            irq_flag_d = 1'b1;
        end
    end

    // ====================================================================
    // routing decode
    ref_ctrl_t ref_d;
    in_ctrl_t in_d;
    logic [11:0] pin_an;

    always_comb begin
        ref_d.gain = gain_t'(gain_q);
        ref_d.amp_power = ampen_q;
        ref_d.amp_from_bandgap = ampin_q;
        ref_d.amp_pin_connect = !ampin_q;
        if (refsel_q[1]) begin
            ref_d.ref_route = REF_AMP_OUT;
        end else if (refsel_q[0]) begin
            ref_d.ref_route = REF_EXT_PIN;
        end else begin
            ref_d.ref_route = REF_SUPPLY;
        end
        ref_d.ext_ref_connect = (refsel_q == 2'h1);
        in_d.channel_onehot = 12'h000;
        case (src_q)
            4'h1: in_d.in_route = IN_SUPPLY;
            4'h2: in_d.in_route = IN_SUPPLY_HALF;
            4'h3: in_d.in_route = IN_SUPPLY_QUARTER;
            4'h5: in_d.in_route = IN_AMP;
            4'h6: in_d.in_route = IN_AMP_HALF;
            4'h7: in_d.in_route = IN_AMP_QUARTER;
            4'h8, 4'h9, 4'hA, 4'hB: in_d.in_route = IN_GROUND;
            default: begin
                in_d.in_route = IN_EXT_CHANNEL;
                if (chan_q < 4'hC) begin
                    in_d.channel_onehot = 12'(13'h0001 << chan_q);
                end
            end
        endcase
        pin_an = pinsel_q;
    end

    // ====================================================================
    // registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            chan_q <= 4'h0;
            start_q <= 1'b0;
            pwr_q <= 1'b0;
            ckdiv_q <= 3'h0;
            src_q <= 4'h0;
            gain_q <= 2'h0;
            refsel_q <= 2'h0;
            ampin_q <= 1'b0;
            ampen_q <= 1'b0;
            bgap_q <= 1'b0;
            pinsel_q <= `RST_PINSEL;
            irq_flag_q <= 1'b0;
            start_armed_q <= 1'b0;
            div_q <= 7'h00;
            st_q <= SEQ_IDLE;
            cnt_q <= 5'h00;
            REF_CTRL <= '0;
            IN_CTRL <= '0;
            CONVERTER_POWER <= 1'b0;
            CONV_CLOCK_EN <= 1'b0;
            SAMPLE_PHASE <= 1'b0;
            CONVERT_PHASE <= 1'b0;
            CONV_DONE_IRQ <= 1'b0;
            BANDGAP_ENABLE <= 1'b0;
            PIN_ANALOG_MODE <= 12'h000;
            PIN_DIGITAL_DISABLE <= 12'h000;
            PIN_PULLUP_DISCONNECT <= 12'h000;
            PIN_DIR_INPUT_FORCE <= 12'h000;
        end else begin
            aw_hold_q <= aw_hold_d;
            aw_addr_q <= aw_addr_d;
            w_hold_q <= w_hold_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            chan_q <= chan_d;
            start_q <= start_d;
            pwr_q <= pwr_d;
            ckdiv_q <= ckdiv_d;
            src_q <= src_d;
            gain_q <= gain_d;
            refsel_q <= refsel_d;
            ampin_q <= ampin_d;
            ampen_q <= ampen_d;
            bgap_q <= bgap_d;
            pinsel_q <= pinsel_d;
            irq_flag_q <= irq_flag_d;
            start_armed_q <= start_armed_d;
            div_q <= div_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            REF_CTRL <= ref_d;
            IN_CTRL <= in_d;
            CONVERTER_POWER <= pwr_d;
            CONV_CLOCK_EN <= tick && (st_q != SEQ_IDLE);
            SAMPLE_PHASE <= (st_d == SEQ_SAMPLE);
            CONVERT_PHASE <= (st_d == SEQ_CONVERT);
            CONV_DONE_IRQ <= irq_flag_d;
            BANDGAP_ENABLE <= bgap_d;
            PIN_ANALOG_MODE <= pin_an;
            PIN_DIGITAL_DISABLE <= pin_an;
            PIN_PULLUP_DISCONNECT <= pin_an;
            PIN_DIR_INPUT_FORCE <= pin_an;
        end
    end

    assign AWREADY = !aw_hold_q;
    assign WREADY = !w_hold_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = !rvalid_q;
    assign RVALID = rvalid_q;
    assign RRESP = rresp_q;
    assign RDATA = rdata_q;

endmodule
`default_nettype wire

// ==== verification/adc_core_model.sv ====
// far-side analog core model: measures phase lengths and tick counts
// assumes the sequencer's phase and tick outputs on the same clock
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// core model
module adc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample,
    input wire logic convert,
    input wire logic tick,
    output logic done_in,
    output logic [15:0] busy_len,
    output logic [15:0] samp_len,
    output logic [15:0] tick_cnt
);
    logic busy_q;
    logic samp_q;
    // completion is timed by the sequencer, so the core stays quiet
    assign done_in = 1'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'h0;
            samp_q <= 1'h0;
            busy_len <= '0;
            samp_len <= '0;
            tick_cnt <= '0;
        end else begin
            busy_q <= sample | convert;
            samp_q <= sample;
            if (sample | convert) busy_len <= busy_q ? busy_len + 16'h1 : 16'h1;
            if (sample) samp_len <= samp_q ? samp_len + 16'h1 : 16'h1;
            if ((sample | convert) && !busy_q) tick_cnt <= {15'h0, tick};
            else if ((sample | convert) && tick) tick_cnt <= tick_cnt + 16'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/adc_seq_chk.sv ====
// assertion checker for the converter sequencer outputs
// assumes binding to the sequencer top module
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// checker
module adc_seq_chk
    import adc_seq_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire ref_ctrl_t REF_CTRL,
    input wire in_ctrl_t IN_CTRL,
    input wire logic CONVERTER_POWER,
    input wire logic SAMPLE_PHASE,
    input wire logic CONVERT_PHASE,
    input wire logic CONV_DONE_IRQ,
    input wire logic [11:0] PIN_ANALOG_MODE,
    input wire logic [11:0] PIN_DIGITAL_DISABLE,
    input wire logic [11:0] PIN_PULLUP_DISCONNECT,
    input wire logic [11:0] PIN_DIR_INPUT_FORCE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_off_idle: assert property (
        !CONVERTER_POWER |=> !(SAMPLE_PHASE || CONVERT_PHASE)) else $error("busy while off");
    a_ext_ref_path: assert property (
        REF_CTRL.ext_ref_connect == (REF_CTRL.ref_route == REF_EXT_PIN))
        else $error("reference pin path wrong");
    a_amp_pin_off: assert property (
        REF_CTRL.amp_from_bandgap |-> !REF_CTRL.amp_pin_connect) else $error("amp pin on");
    a_chan_internal: assert property (
        IN_CTRL.in_route != IN_EXT_CHANNEL |-> IN_CTRL.channel_onehot == 12'h000)
        else $error("channel on with internal source");
    a_chan_single: assert property (
        $onehot0(IN_CTRL.channel_onehot)) else $error("several channels on");
    a_pin_override: assert property (
        PIN_DIGITAL_DISABLE == PIN_ANALOG_MODE && PIN_DIR_INPUT_FORCE == PIN_ANALOG_MODE)
        else $error("pin override mismatch");
    a_pullup_drop: assert property (
        PIN_PULLUP_DISCONNECT == PIN_ANALOG_MODE) else $error("pull-high not dropped");
    a_phase_excl: assert property (
        !(SAMPLE_PHASE && CONVERT_PHASE)) else $error("both phases");
    a_sample_first: assert property (
        $rose(CONVERT_PHASE) |-> $past(SAMPLE_PHASE)) else $error("convert without sample");
    a_sample_next: assert property (
        $fell(SAMPLE_PHASE) && CONVERTER_POWER |-> CONVERT_PHASE) else $error("no convert");
    a_done_flag: assert property (
        $fell(CONVERT_PHASE) && CONVERTER_POWER |-> ##[0:1] CONV_DONE_IRQ)
        else $error("flag not set at completion");
    c_conv_done: cover property ($fell(CONVERT_PHASE) && CONVERTER_POWER);
    c_amp_ref: cover property (REF_CTRL.ref_route == REF_AMP_OUT);
    c_ground: cover property (IN_CTRL.in_route == IN_GROUND);
endmodule
bind adc_seq adc_seq_chk chk (.CLK, .RST, .REF_CTRL, .IN_CTRL, .CONVERTER_POWER, .SAMPLE_PHASE,
    .CONVERT_PHASE, .CONV_DONE_IRQ, .PIN_ANALOG_MODE, .PIN_DIGITAL_DISABLE,
    .PIN_PULLUP_DISCONNECT, .PIN_DIR_INPUT_FORCE);
`default_nettype wire

// ==== verification/tb_adc_seq.sv ====
// testbench: registers, routing, pins and conversion timing of the sequencer
// assumes package, constants header, core model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_consts.svh"
// ====================================================================
// bench top
module tb_adc_seq
    import adc_seq_pkg::*;
;
    logic CLK = 1'h0;
    logic RST = 1'h1;
    logic [11:0] AWADDR = '0, ARADDR = '0;
    logic AWVALID = '0, WVALID = '0, BREADY = '0, ARVALID = '0, RREADY = '0;
    logic [31:0] WDATA = '0, RDATA;
    logic [3:0] WSTRB = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_DONE_IN, CONVERTER_POWER;
    logic [1:0] BRESP, RRESP;
    ref_ctrl_t REF_CTRL;
    in_ctrl_t IN_CTRL;
    logic CONV_CLOCK_EN, SAMPLE_PHASE, CONVERT_PHASE, CONV_DONE_IRQ, BANDGAP_ENABLE;
    logic [11:0] PIN_ANALOG_MODE, PIN_DIGITAL_DISABLE, PIN_PULLUP_DISCONNECT, PIN_DIR_INPUT_FORCE;
    logic [15:0] busy_len, samp_len, tick_cnt;
    int failures = 0, cmp_count = 0;
    always #12.5 CLK = ~CLK;
    adc_seq dut (.CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
        .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
        .RREADY, .CONV_DONE_IN, .REF_CTRL, .IN_CTRL, .CONVERTER_POWER, .CONV_CLOCK_EN,
        .SAMPLE_PHASE, .CONVERT_PHASE, .CONV_DONE_IRQ, .BANDGAP_ENABLE, .PIN_ANALOG_MODE,
        .PIN_DIGITAL_DISABLE, .PIN_PULLUP_DISCONNECT, .PIN_DIR_INPUT_FORCE);
    adc_core_model core (.clk(CLK), .rst(RST), .sample(SAMPLE_PHASE), .convert(CONVERT_PHASE),
        .tick(CONV_CLOCK_EN), .done_in(CONV_DONE_IN), .busy_len, .samp_len, .tick_cnt);
    task automatic finish_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stuck(input string nm);
        failures++;
        $display("BAD %s wait expired", nm);
        finish_test();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
        output logic [1:0] r);
        int n;
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= v;
        WSTRB <= s;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'h0;
            if (WVALID && WREADY) WVALID <= 1'h0;
            if (BVALID && BREADY) begin
                r = BRESP;
                BREADY <= 1'h0;
                break;
            end
        end
        if (n == 40) stuck("write");
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'h0;
            if (RVALID && RREADY) begin
                d = RDATA;
                r = RRESP;
                RREADY <= 1'h0;
                break;
            end
        end
        if (n == 40) stuck("read");
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] v);
        logic [1:0] r;
        wr(a, v, 4'hF, r);
        chk("bresp", 32'h0, {30'h0, r});
        cyc(2);
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 5; i++) begin
            rd(12'(4 * i), d, r);
            chk("reset value", 32'h0, d);
        end
        rd(12'h014, d, r);
        chk("unmapped rresp", 32'h3, {30'h0, r});
        chk("unmapped rdata", 32'h0, d);
        wr(12'h014, 32'hFFFF_FFFF, 4'hF, r);
        chk("unmapped bresp", 32'h3, {30'h0, r});
        w(`OFS_CTRL0, 32'h0000_0040);
        rd(`OFS_CTRL0, d, r);
        chk("busy read-only", 32'h0, d);
        $display("registers done");
    endtask
    task automatic t_ref;
        w(`OFS_BGAP, 32'h1);
        chk("bandgap", 32'h1, BANDGAP_ENABLE);
        for (int i = 0; i < 4; i++) begin
            w(`OFS_CTRL2, 32'(i | i << 2 | (i & 1) << 4 | (i >> 1) << 7));
            chk("ref route", i[1] ? REF_AMP_OUT : i, REF_CTRL.ref_route);
            chk("ext ref", i == 1, REF_CTRL.ext_ref_connect);
            chk("gain", i, REF_CTRL.gain);
            chk("amp power", i >> 1, REF_CTRL.amp_power);
            chk("amp input", i & 1, REF_CTRL.amp_from_bandgap);
            if (i >= 2) chk("amp pin", i == 2, REF_CTRL.amp_pin_connect);
        end
        $display("reference done");
    endtask
    task automatic t_input;
        int ex;
        for (int i = 0; i < 16; i++) begin
            ex = (i == 0 || i == 4 || i >= 12);
            w(`OFS_CTRL1, 32'(i << 4));
            w(`OFS_CTRL0, 32'(i));
            chk("in route", ex ? 0 : i < 4 ? i : i < 8 ? i - 1 : IN_GROUND,
                IN_CTRL.in_route);
            chk("channels", (ex && i < 12) ? 1 << i : 0, IN_CTRL.channel_onehot);
            w(`OFS_CTRL1, 32'hC0);
            chk("ext channel", i < 12 ? 1 << i : 0, IN_CTRL.channel_onehot);
        end
        $display("input routing done");
    endtask
    task automatic t_pins;
        logic [1:0] r;
        w(`OFS_PINSEL, 32'hA5C);
        chk("analog mode", 32'hA5C, PIN_ANALOG_MODE);
        chk("digital off", 32'hA5C, PIN_DIGITAL_DISABLE);
        chk("pull-high off", 32'hA5C, PIN_PULLUP_DISCONNECT);
        chk("dir force", 32'hA5C, PIN_DIR_INPUT_FORCE);
        wr(`OFS_PINSEL, 32'hFFF, 4'h1, r);
        cyc(2);
        chk("lane 0 only", 32'hAFF, PIN_ANALOG_MODE);
        $display("pins done");
    endtask
    task automatic t_conv;
        logic [31:0] d;
        logic [1:0] r;
        int dv;
        int n;
        for (int c = 0; c < 8; c++) begin
            dv = 1 << c;
            w(`OFS_CTRL1, 32'(c));
            w(`OFS_CTRL0, 32'h20);
            cyc(4);
            w(`OFS_CTRL0, 32'h30);
            chk("no start on rise", 32'h0, SAMPLE_PHASE | CONVERT_PHASE);
            wr(`OFS_CTRL0, 32'h20, 4'hF, r);
            cyc(1);
            chk("busy", 32'h1, SAMPLE_PHASE);
            rd(`OFS_CTRL0, d, r);
            chk("busy bit", 32'h1, d[6]);
            if (c >= 2) w(`OFS_CTRL0, 32'h30);
            if (c >= 2) w(`OFS_CTRL0, 32'h20);
            for (n = 0; n < 3000 && (SAMPLE_PHASE | CONVERT_PHASE); n++) @(posedge CLK);
            if (n == 3000) stuck("conversion");
            cyc(1);
            chk("busy len", 32'h1, busy_len >= 15 * dv + 1 && busy_len <= 16 * dv + 1);
            chk("sample length", 32'h1, samp_len >= 3 * dv + 1 && samp_len <= 4 * dv + 1);
            chk("ticks", 32'h1, tick_cnt >= 15 && tick_cnt <= 17);
            rd(`OFS_CTRL0, d, r);
            chk("flag and busy", 32'h2, d[7:6]);
            w(`OFS_CTRL0, 32'hA0);
            chk("flag kept", 32'h1, CONV_DONE_IRQ);
            w(`OFS_CTRL0, 32'h20);
            chk("flag cleared", 32'h0, CONV_DONE_IRQ);
        end
        $display("conversion done");
    endtask
    task automatic t_refuse;
        w(`OFS_CTRL0, 32'h10);
        w(`OFS_CTRL0, 32'h00);
        cyc(3);
        chk("start while off", 32'h0, {CONVERTER_POWER, SAMPLE_PHASE, CONVERT_PHASE});
        w(`OFS_CTRL1, 32'h7);
        w(`OFS_CTRL0, 32'h20);
        chk("power", 32'h1, CONVERTER_POWER);
        w(`OFS_CTRL0, 32'h30);
        w(`OFS_CTRL0, 32'h20);
        cyc(20);
        chk("running", 32'h1, SAMPLE_PHASE | CONVERT_PHASE);
        w(`OFS_CTRL0, 32'h00);
        chk("abort", 32'h0, {CONVERTER_POWER, SAMPLE_PHASE, CONVERT_PHASE});
        $display("refusal done");
    endtask
    initial begin
        cyc(3);
        RST <= 1'h0;
        t_regs();
        t_ref();
        t_input();
        t_pins();
        t_conv();
        t_refuse();
        finish_test();
    end
endmodule
`default_nettype wire
